/* File: src/mldc_pkg.sv */
// holds the constants shared by the line driver control block.
// assumes an 8-bit processor i/o bus with a 16-bit i/o address.
package mldc_pkg;

   localparam int unsigned ADDR_W = 16;
   localparam int unsigned DATA_W = 8;

   // i/o address of the board control register
   localparam logic [ADDR_W-1:0] BOARD_CONTROL_ADDR = 16'h01da;

   // field positions inside the board control register
   localparam int unsigned BIT_C_FULLDUPLEX_TX = 0;
   localparam int unsigned BIT_C_RECEIVER      = 1;
   localparam int unsigned BIT_C_HALFDUPLEX_TX = 2;
   localparam int unsigned BIT_RESERVED_LOW    = 3;
   localparam int unsigned BIT_D_FULLDUPLEX_TX = 4;
   localparam int unsigned BIT_D_RECEIVER      = 5;
   localparam int unsigned BIT_D_HALFDUPLEX_TX = 6;
   localparam int unsigned BIT_RESERVED_HIGH   = 7;

   // writable bits; the reserved bits 7 and 3 are dropped
   localparam logic [DATA_W-1:0] WRITE_MASK = 8'h77;

   // all enables cleared after reset
   localparam logic [DATA_W-1:0] RESET_VALUE = 8'h00;

   // value that puts both ports into four-wire operation
   localparam logic [DATA_W-1:0] BOTH_FULLDUPLEX_VALUE = 8'h33;

   // number of differential serial ports handled
   localparam int unsigned NUM_PORTS = 2;

   // idle (mark) level on a serial data line
   localparam logic LINE_IDLE = 1'b1;

endpackage : mldc_pkg

/* File: src/mldc_port_xcvr.sv */
// holds the line steering of one differential serial port.
// assumes single-ended stand-ins for each differential pair and a uart
// core on the user side.
module mldc_port_xcvr
(
   input  wire logic clk,
   input  wire logic arst_n,
   input  wire logic fullduplex_tx_enable,
   input  wire logic receiver_enable,
   input  wire logic halfduplex_tx_enable,
   input  wire logic uart_txd,
   output logic      uart_rxd,
   output logic      tx_pair_out,
   output logic      tx_pair_oe,
   input  wire logic rx_pair_in,
   output logic      rx_pair_out,
   output logic      rx_pair_oe
);

   typedef struct packed
   {
      logic rxd;
      logic tx_out;
      logic tx_oe;
      logic rx_out;
      logic rx_oe;
   } mldc_xcvr_state_t;

   mldc_xcvr_state_t state;
   mldc_xcvr_state_t next_state;

   always_comb
   begin
      next_state = state;
      // four-wire: dedicated transmit pair
      next_state.tx_oe  = fullduplex_tx_enable;          // see R13
      next_state.tx_out = uart_txd;
      // two-wire: transmit on the shared receive pair
      next_state.rx_oe  = halfduplex_tx_enable;          // see R13
      next_state.rx_out = uart_txd;
      // own driver on the shared pair is heard back for collision checks
      if (!receiver_enable)
         next_state.rxd = mldc_pkg::LINE_IDLE;
      else if (halfduplex_tx_enable)
         next_state.rxd = uart_txd;                      // see R11
      else
         next_state.rxd = rx_pair_in;
   end

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         state <= '{rxd:    mldc_pkg::LINE_IDLE,
                    tx_out: mldc_pkg::LINE_IDLE,
                    tx_oe:  1'b0,
                    rx_out: mldc_pkg::LINE_IDLE,
                    rx_oe:  1'b0};
      end
      else
      begin
         state <= next_state;
      end
   end

   assign uart_rxd    = state.rxd;
   assign tx_pair_out = state.tx_out;
   assign tx_pair_oe  = state.tx_oe;
   assign rx_pair_out = state.rx_out;
   assign rx_pair_oe  = state.rx_oe;

   a_echo_loop: assert property (@(posedge clk) disable iff (!arst_n) // see R11
      receiver_enable && halfduplex_tx_enable |=> uart_rxd == $past(uart_txd))
      else $error("receiver does not echo the half-duplex transmit data");

   a_pair_split: assert property (@(posedge clk) disable iff (!arst_n) // see R13
      !halfduplex_tx_enable |=> !rx_pair_oe && (tx_pair_oe == $past(fullduplex_tx_enable)))
      else $error("pair drive does not follow the duplex enables");

endmodule : mldc_port_xcvr

/* File: src/mldc_line_ctrl.sv */
// holds the board control register that steers the multidrop_line_driver_control transceivers of
// serial ports c and d, and the line steering of both ports.
// assumes an 8-bit i/o bus with one-cycle read and write strobes, synchronous
// to clk, and the uart cores outside this block.
//
// Overview of operation
// R1 - bit 6 enables port d two-wire driver
// R2 - bit 5 enables port d receiver
// R3 - bit 4 enables port d four-wire driver
// R4 - bit 2 enables port c two-wire driver
// R5 - bit 1 enables port c receiver
// R6 - bit 0 enables port c four-wire driver
// R7 - bits 7 and 3 reserved, writes ignored
// R8 - register read and written at 1dah
// R9 - writing 33h selects four-wire on both ports
// R10 - software drops two-wire driver after last byte
// R11 - two-wire port hears its own transmit data
// R12 - software may leave receivers always enabled
// R13 - four-wire uses two pairs, two-wire one
// R14 - reset clears all six enables
module mldc_line_ctrl
(
   input  wire logic                        clk,
   input  wire logic                        arst_n,
   // processor i/o bus
   input  wire logic [mldc_pkg::ADDR_W-1:0] io_addr,
   input  wire logic                        io_wr,
   input  wire logic                        io_rd,
   input  wire logic [mldc_pkg::DATA_W-1:0] io_wdata,
   output logic      [mldc_pkg::DATA_W-1:0] io_rdata,
   output logic                             io_rvalid,
   // transceiver enables
   output logic                             port_c_fullduplex_tx_enable,
   output logic                             port_c_receiver_enable,
   output logic                             port_c_halfduplex_tx_enable,
   output logic                             port_d_fullduplex_tx_enable,
   output logic                             port_d_receiver_enable,
   output logic                             port_d_halfduplex_tx_enable,
   // uart side, index 0 is port c, index 1 is port d
   input  wire logic [mldc_pkg::NUM_PORTS-1:0] uart_txd,
   output logic      [mldc_pkg::NUM_PORTS-1:0] uart_rxd,
   // line side
   output logic      [mldc_pkg::NUM_PORTS-1:0] tx_pair_out,
   output logic      [mldc_pkg::NUM_PORTS-1:0] tx_pair_oe,
   input  wire logic [mldc_pkg::NUM_PORTS-1:0] rx_pair_in,
   output logic      [mldc_pkg::NUM_PORTS-1:0] rx_pair_out,
   output logic      [mldc_pkg::NUM_PORTS-1:0] rx_pair_oe
);

   typedef struct packed
   {
      logic [mldc_pkg::DATA_W-1:0] board_control_register;
      logic [mldc_pkg::DATA_W-1:0] rdata;
      logic                        rvalid;
   } mldc_top_state_t;

   mldc_top_state_t state;
   mldc_top_state_t next_state;

   logic [mldc_pkg::NUM_PORTS-1:0] fd_en;
   logic [mldc_pkg::NUM_PORTS-1:0] rx_en;
   logic [mldc_pkg::NUM_PORTS-1:0] hd_en;
   logic                           wr_hit;
   logic                           rd_hit;

   // full 16-bit decode so aliases of the register do not respond
   function automatic logic addr_hit
   (
      input logic [mldc_pkg::ADDR_W-1:0] addr
   );
      addr_hit = (addr == mldc_pkg::BOARD_CONTROL_ADDR);
   endfunction : addr_hit

   assign wr_hit = io_wr && addr_hit(io_addr);            // see R8
   assign rd_hit = io_rd && addr_hit(io_addr);            // see R8

   always_comb
   begin
      next_state        = state;
      next_state.rvalid = 1'b0;
      // reserved bits are dropped and stay zero
      if (wr_hit)
      begin
         next_state.board_control_register = io_wdata & mldc_pkg::WRITE_MASK; // see R7 see R9
      end
      // a read in the same cycle as a write returns the old value
      if (rd_hit)
      begin
         next_state.rdata  = state.board_control_register;
         next_state.rvalid = 1'b1;
      end
   end

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         state.board_control_register <= mldc_pkg::RESET_VALUE; // see R14
         state.rdata                  <= mldc_pkg::RESET_VALUE;
         state.rvalid                 <= 1'b0;
      end
      else
      begin
         state <= next_state;
      end
   end

   assign io_rdata  = state.rdata;
   assign io_rvalid = state.rvalid;

   assign port_c_fullduplex_tx_enable = state.board_control_register[mldc_pkg::BIT_C_FULLDUPLEX_TX]; // see R6
   assign port_c_receiver_enable      = state.board_control_register[mldc_pkg::BIT_C_RECEIVER];      // see R5
   assign port_c_halfduplex_tx_enable = state.board_control_register[mldc_pkg::BIT_C_HALFDUPLEX_TX]; // see R4
   assign port_d_fullduplex_tx_enable = state.board_control_register[mldc_pkg::BIT_D_FULLDUPLEX_TX]; // see R3
   assign port_d_receiver_enable      = state.board_control_register[mldc_pkg::BIT_D_RECEIVER];      // see R2
   assign port_d_halfduplex_tx_enable = state.board_control_register[mldc_pkg::BIT_D_HALFDUPLEX_TX]; // see R1

   assign fd_en = {port_d_fullduplex_tx_enable, port_c_fullduplex_tx_enable};
   assign rx_en = {port_d_receiver_enable, port_c_receiver_enable};
   assign hd_en = {port_d_halfduplex_tx_enable, port_c_halfduplex_tx_enable};

   // one line steering instance per port; the two-wire driver stays on until
   // software clears it after the last stop bit has left the uart
   generate
      for (genvar p = 0; p < mldc_pkg::NUM_PORTS; p++)
      begin : g_port
         mldc_port_xcvr u_xcvr
         (
            .clk                  (clk),
            .arst_n               (arst_n),
            .fullduplex_tx_enable (fd_en[p]),
            .receiver_enable      (rx_en[p]),
            .halfduplex_tx_enable (hd_en[p]),
            .uart_txd             (uart_txd[p]),
            .uart_rxd             (uart_rxd[p]),
            .tx_pair_out          (tx_pair_out[p]),
            .tx_pair_oe           (tx_pair_oe[p]),
            .rx_pair_in           (rx_pair_in[p]),
            .rx_pair_out          (rx_pair_out[p]),
            .rx_pair_oe           (rx_pair_oe[p])
         );
      end
   endgenerate

   default clocking cb @(posedge clk);
   endclocking

   default disable iff (!arst_n);

   a_port_d_bits: assert property ( // see R1
      wr_hit |=> port_d_halfduplex_tx_enable == $past(io_wdata[mldc_pkg::BIT_D_HALFDUPLEX_TX])
              && port_d_receiver_enable == $past(io_wdata[mldc_pkg::BIT_D_RECEIVER])
              && port_d_fullduplex_tx_enable == $past(io_wdata[mldc_pkg::BIT_D_FULLDUPLEX_TX]))
      else $error("port d enables do not follow the written value");

   a_port_d_recv: assert property ( // see R2
      port_d_receiver_enable && !wr_hit |=> port_d_receiver_enable)
      else $error("port d receiver enable dropped without a write");

   a_port_d_four: assert property ( // see R3
      wr_hit && io_wdata[mldc_pkg::BIT_D_FULLDUPLEX_TX] |=> ##1 tx_pair_oe[1])
      else $error("port d four-wire driver not enabled two cycles after write");

   a_port_c_bits: assert property ( // see R4
      wr_hit |=> port_c_halfduplex_tx_enable == $past(io_wdata[mldc_pkg::BIT_C_HALFDUPLEX_TX])
              && port_c_receiver_enable == $past(io_wdata[mldc_pkg::BIT_C_RECEIVER])
              && port_c_fullduplex_tx_enable == $past(io_wdata[mldc_pkg::BIT_C_FULLDUPLEX_TX]))
      else $error("port c enables do not follow the written value");

   a_port_c_recv: assert property ( // see R5
      wr_hit && !io_wdata[mldc_pkg::BIT_C_RECEIVER] |=> ##1 uart_rxd[0] == mldc_pkg::LINE_IDLE)
      else $error("port c receive data not idle after receiver disable");

   a_port_c_four: assert property ( // see R6
      wr_hit && !io_wdata[mldc_pkg::BIT_C_FULLDUPLEX_TX] |=> ##1 !tx_pair_oe[0])
      else $error("port c four-wire driver still on after disable");

   a_reserved_zero: assert property ( // see R7
      !state.board_control_register[mldc_pkg::BIT_RESERVED_HIGH]
      && !state.board_control_register[mldc_pkg::BIT_RESERVED_LOW])
      else $error("reserved bit of control register set");

   a_read_back: assert property ( // see R8
      rd_hit |=> io_rvalid && io_rdata == $past(state.board_control_register))
      else $error("read of control register returned wrong value");

   a_miss_ignored: assert property ( // see R8
      io_wr && !addr_hit(io_addr) |=> $stable(state.board_control_register))
      else $error("write to another address changed the control register");

   a_rvalid_cause: assert property ( // see R8
      io_rvalid |-> $past(rd_hit))
      else $error("read answer without a read");

   a_four_wire_both: assert property ( // see R9
      wr_hit && io_wdata == mldc_pkg::BOTH_FULLDUPLEX_VALUE |=>
         port_c_fullduplex_tx_enable && port_c_receiver_enable && !port_c_halfduplex_tx_enable
         && port_d_fullduplex_tx_enable && port_d_receiver_enable && !port_d_halfduplex_tx_enable)
      else $error("writing 33h did not select four-wire on both ports");

   a_reset_clear: assert property (@(posedge clk) disable iff (1'b0) // see R14
      !arst_n |-> state.board_control_register == mldc_pkg::RESET_VALUE && !io_rvalid)
      else $error("enables not cleared during reset");

   a_rdata_hold: assert property ( // see R8
      !rd_hit |=> $stable(io_rdata))
      else $error("read data changed without a read");

   a_enables_hold: assert property ( // see R1
      !wr_hit |=> $stable(state.board_control_register))
      else $error("enables changed without a write");

   a_shared_pair_d: assert property ( // see R13
      hd_en[1] |=> rx_pair_oe[1] && rx_pair_out[1] == $past(uart_txd[1]))
      else $error("port d two-wire driver not on the shared pair");

   a_echo_port_d: assert property ( // see R11
      hd_en[1] && rx_en[1] |=> uart_rxd[1] == $past(uart_txd[1]))
      else $error("port d does not hear its own transmit data");

   c_four_wire: cover property (wr_hit && io_wdata == mldc_pkg::BOTH_FULLDUPLEX_VALUE);

   c_two_wire_echo: cover property (hd_en[1] && rx_en[1] && $changed(uart_txd[1]));

   c_read: cover property (rd_hit ##1 io_rvalid && io_rdata != mldc_pkg::RESET_VALUE);

   c_driver_off: cover property (hd_en[0] ##1 !hd_en[0]);

endmodule : mldc_line_ctrl

/* File: testbench/mldc_host_model.sv */
// holds a host processor model that reads and writes the board control register.
// assumes one-cycle strobes launched on the rising edge of clk and a registered read answer.
module mldc_host_model
(
   input  wire logic                        clk,
   output logic      [mldc_pkg::ADDR_W-1:0] io_addr,
   output logic                             io_wr,
   output logic                             io_rd,
   output logic      [mldc_pkg::DATA_W-1:0] io_wdata,
   input  wire logic [mldc_pkg::DATA_W-1:0] io_rdata,
   input  wire logic                        io_rvalid
);
   timeunit 1ns;
   timeprecision 1ps;

   initial
   begin
      io_addr  = 16'h0000;
      io_wr    = 1'b0;
      io_rd    = 1'b0;
      io_wdata = 8'h00;
   end

   // released bus lines show the inverse of the last value
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge clk);
      io_wr    <= 1'b1;
      io_addr  <= a;
      io_wdata <= d;
      @(posedge clk);
      io_wr    <= 1'b0;
      io_addr  <= ~a;
      io_wdata <= ~d;
   endtask : wr

   // the answer is taken at the falling edge half a cycle after the taking edge
   task automatic rd(input logic [15:0] a, output logic [7:0] d, output logic v);
      @(posedge clk);
      io_rd   <= 1'b1;
      io_addr <= a;
      @(posedge clk);
      io_rd   <= 1'b0;
      io_addr <= ~a;
      @(negedge clk);
      v = io_rvalid;
      d = io_rdata;
   endtask : rd
endmodule : mldc_host_model

/* File: testbench/testbench.sv */
// holds the self-checking bench of the line driver control block.
// assumes the host model on the i/o bus; the bench drives the line and uart inputs.
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk, arst_n, io_wr, io_rd, io_rvalid, ok;
   logic [15:0] io_addr;
   logic [7:0]  io_wdata, io_rdata, shadow, got;
   logic        c_fd, c_rx, c_hd, d_fd, d_rx, d_hd;
   logic [1:0]  uart_txd, uart_rxd, tx_pair_out, tx_pair_oe, rx_pair_in, rx_pair_out, rx_pair_oe;
   logic [7:0]  corner [6] = '{8'h33, 8'hff, 8'h66, 8'h22, 8'h44, 8'h00};
   int          fail_count, num_checks;

   mldc_host_model i_host (.clk(clk), .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd),
      .io_wdata(io_wdata), .io_rdata(io_rdata), .io_rvalid(io_rvalid));
   mldc_line_ctrl i_dut (.clk(clk), .arst_n(arst_n), .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd),
      .io_wdata(io_wdata), .io_rdata(io_rdata), .io_rvalid(io_rvalid),
      .port_c_fullduplex_tx_enable(c_fd), .port_c_receiver_enable(c_rx), .port_c_halfduplex_tx_enable(c_hd),
      .port_d_fullduplex_tx_enable(d_fd), .port_d_receiver_enable(d_rx), .port_d_halfduplex_tx_enable(d_hd),
      .uart_txd(uart_txd), .uart_rxd(uart_rxd), .tx_pair_out(tx_pair_out), .tx_pair_oe(tx_pair_oe),
      .rx_pair_in(rx_pair_in), .rx_pair_out(rx_pair_out), .rx_pair_oe(rx_pair_oe));

   initial
   begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   task automatic test_done;
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : test_done

   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] seen);
      num_checks++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk

   // packs tx drive enables, shared pair enables, uart receive data and tx pair levels
   function automatic logic [7:0] exp_link(logic [7:0] r, logic [1:0] t, logic [1:0] ri);
      logic [1:0] fd, rx, hd, ur;
      fd = {r[4], r[0]};
      rx = {r[5], r[1]};
      hd = {r[6], r[2]};
      ur = ~rx | (hd & t) | (~hd & ri);
      return {fd, hd, ur, t};
   endfunction : exp_link

   task automatic do_reset;
      @(posedge clk);
      arst_n <= 1'b0;
      repeat (16) @(posedge clk);
      arst_n <= 1'b1;
      shadow = 8'h00;
      @(negedge clk);
      chk("reset enables", 8'h00, {2'b00, c_fd, c_rx, c_hd, d_fd, d_rx, d_hd});
      chk("reset line", 8'h0c, {tx_pair_oe, rx_pair_oe, uart_rxd, 2'b00});
      chk("reset read", 8'h00, io_rdata | {7'h00, io_rvalid});
   endtask : do_reset

   task automatic put(input logic [15:0] a, input logic [7:0] v);
      i_host.wr(a, v);
      if (a === mldc_pkg::BOARD_CONTROL_ADDR)
         shadow = v & mldc_pkg::WRITE_MASK;
      @(negedge clk);
      chk("enables", shadow, {1'b0, d_hd, d_rx, d_fd, 1'b0, c_hd, c_rx, c_fd});
      i_host.rd(a, got, ok);
      chk("answer", {7'h00, a === 16'h01da}, {7'h00, ok});
      if (ok === 1'b1)
         chk("read data", shadow, got);
      @(posedge clk);
      uart_txd   <= 2'($urandom);
      rx_pair_in <= 2'($urandom);
      repeat (3) @(posedge clk);
      @(negedge clk);
      chk("line", exp_link(shadow, uart_txd, rx_pair_in), {tx_pair_oe, rx_pair_oe, uart_rxd, tx_pair_out});
      chk("shared pair", {6'h00, uart_txd & rx_pair_oe}, {6'h00, rx_pair_out & rx_pair_oe});
   endtask : put

   initial
   begin
      // about 8 cycles per access, far below this span
      #1000000;
      fail_count++;
      test_done;
   end

   initial
   begin
      // nonblocking, so the reset edge at time zero is not lost to a start-up race
      arst_n     <= 1'b0;
      uart_txd   = 2'b11;
      rx_pair_in = 2'b11;
      fail_count = 0;
      num_checks = 0;
      void'($urandom(96883));
      do_reset;
      // receivers stay on from 66h to 22h while the two-wire drivers are dropped after sending
      foreach (corner[i])
         put(16'h01da, corner[i]);
      put(16'h01da, 8'h77);
      put(16'h01db, 8'h00);
      put(16'h00da, 8'h00);
      for (int i = 0; i < 40; i++)
         put(($urandom % 4 == 0) ? 16'h01d8 + 16'($urandom % 4) : 16'h01da, 8'($urandom));
      put(16'h01da, 8'h33);
      do_reset;
      put(16'h01da, 8'h66);
      test_done;
   end
endmodule : testbench
